// >>> hdl/flash_cmd_pkg.sv
// Opcodes, status field layout, identity codes and states of the command interpreter
package flash_cmd_pkg;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_STATUS_ARM = 8'h50;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_READ_ID_A = 8'h90;
  localparam logic [7:0] OP_READ_ID_B = 8'hAB;

  // ----------------------------------------------------------------
  // Identity codes (values arbitrary)
  // ----------------------------------------------------------------
  localparam logic [7:0] MAKER_CODE = 8'hA5;
  localparam logic [7:0] PART_CODE = 8'h5A;

  // ----------------------------------------------------------------
  // Status byte field positions and reset values
  // ----------------------------------------------------------------
  localparam int BP_LO_POS = 2;
  localparam int BP_HI_POS = 3;
  localparam int LOCK_POS = 7;
  localparam logic STATUS_BIT_RST = 1'b0;

  // ----------------------------------------------------------------
  // Shift counts and synchroniser reset pattern
  // ----------------------------------------------------------------
  localparam logic [4:0] LAST_BYTE_BIT = 5'h07;
  localparam logic [4:0] LAST_ADDR_BIT = 5'h17;
  localparam logic [2:0] BIT_MSB = 3'h7;
  localparam logic [3:0] PIN_SYNC_RST = 4'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CMD  = 3'b001,
    ST_ADDR = 3'b010,
    ST_DATA = 3'b011,
    ST_ID   = 3'b100,
    ST_SKIP = 3'b101
  } cmd_state_e;

endpackage

// >>> hdl/flash_status_protect_id_cmds.sv
// Serial flash command interpreter: write enable/disable, protected status write, ID read
`timescale 1ns/1ps
module flash_status_protect_id_cmds (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic wp_n,
  input wire logic auto_increment_set,
  output logic miso,
  output logic miso_oe,
  output logic write_enable_latch,
  output logic auto_increment_program_flag,
  output logic block_protect_lo,
  output logic block_protect_hi,
  output logic protect_lock_bit,
  output logic status_armed
);

  spi_events_if ev ();

  pin_sync u_pin_sync (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .sck(sck),
    .cs_n(cs_n),
    .mosi(mosi),
    .wp_n(wp_n),
    .ev(ev)
  );

  flash_cmd_pkg::cmd_state_e state;
  flash_cmd_pkg::cmd_state_e next_state;
  logic [7:0] shreg;
  logic [7:0] opcode;
  logic [7:0] wr_data;
  logic [4:0] bit_cnt;
  logic [2:0] id_idx;
  logic id_sel;
  logic cmd_ok;
  logic data_ok;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire rise = ce & ev.sck_rise & ev.selected & ~ev.cs_fall;
  wire fall = ce & ev.sck_fall & ev.selected & (state == flash_cmd_pkg::ST_ID);
  wire [7:0] next_shreg = {shreg[6:0], ev.din};
  wire byte_done = rise & (bit_cnt == flash_cmd_pkg::LAST_BYTE_BIT);
  wire addr_done = rise & (bit_cnt == flash_cmd_pkg::LAST_ADDR_BIT);
  wire is_id_op = (next_shreg == flash_cmd_pkg::OP_READ_ID_A)
                | (next_shreg == flash_cmd_pkg::OP_READ_ID_B);
  wire cs_end = ce & ev.cs_rise;
  wire exec = cs_end & cmd_ok;
  wire write_disable_exec = exec & (opcode == flash_cmd_pkg::OP_WRITE_DISABLE);
  wire write_enable_exec = exec & (opcode == flash_cmd_pkg::OP_WRITE_ENABLE);
  wire arm_exec = exec & (opcode == flash_cmd_pkg::OP_STATUS_ARM);
  wire status_write_exec = exec & (opcode == flash_cmd_pkg::OP_STATUS_WRITE) & data_ok
                         & status_armed;
  wire status_open = ~protect_lock_bit | ev.wp_high;
  wire status_write_apply = status_write_exec & status_open;
  wire [7:0] id_byte = id_sel ? flash_cmd_pkg::PART_CODE : flash_cmd_pkg::MAKER_CODE;

  always_comb begin
    next_state = state;
    case (state)
      flash_cmd_pkg::ST_CMD: begin
        if (byte_done) begin
          if (is_id_op) begin
            next_state = flash_cmd_pkg::ST_ADDR;
          end else if (next_shreg == flash_cmd_pkg::OP_STATUS_WRITE) begin
            next_state = flash_cmd_pkg::ST_DATA;
          end else begin
            next_state = flash_cmd_pkg::ST_SKIP;
          end
        end
      end
      flash_cmd_pkg::ST_ADDR: begin
        if (addr_done) begin
          next_state = flash_cmd_pkg::ST_ID;
        end
      end
      flash_cmd_pkg::ST_DATA: begin
        if (byte_done) begin
          next_state = flash_cmd_pkg::ST_SKIP;
        end
      end
      flash_cmd_pkg::ST_ID: next_state = flash_cmd_pkg::ST_ID;
      flash_cmd_pkg::ST_SKIP: next_state = flash_cmd_pkg::ST_SKIP;
      flash_cmd_pkg::ST_IDLE: next_state = flash_cmd_pkg::ST_IDLE;
      default: next_state = flash_cmd_pkg::ST_IDLE;
    endcase
    if (ce & ev.cs_fall) begin
      next_state = flash_cmd_pkg::ST_CMD;
    end
    if (cs_end) begin
      next_state = flash_cmd_pkg::ST_IDLE;
    end
  end

  wire phase_end = (next_state != state);

  // ----------------------------------------------------------------
  // Shifter and framing
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= flash_cmd_pkg::ST_IDLE;
      shreg <= 8'h00;
      bit_cnt <= 5'h00;
    end else if (ce) begin
      state <= next_state;
      if (ev.cs_fall | phase_end) begin
        bit_cnt <= 5'h00;
      end else if (rise) begin
        bit_cnt <= bit_cnt + 5'h01;
      end
      if (rise) begin
        shreg <= next_shreg;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      opcode <= 8'h00;
      wr_data <= 8'h00;
      cmd_ok <= 1'b0;
      data_ok <= 1'b0;
    end else if (ce) begin
      if (ev.cs_fall) begin
        cmd_ok <= 1'b0;
        data_ok <= 1'b0;
      end else if (byte_done & (state == flash_cmd_pkg::ST_CMD)) begin
        opcode <= next_shreg;
        cmd_ok <= 1'b1;
      end else if (byte_done & (state == flash_cmd_pkg::ST_DATA)) begin
        wr_data <= next_shreg;
        data_ok <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Write-enable latch, auto-increment flag, arming
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      write_enable_latch <= 1'b0;
      auto_increment_program_flag <= 1'b0;
      status_armed <= 1'b0;
    end else if (ce) begin
      if (write_enable_exec) begin
        write_enable_latch <= 1'b1;
      end else if (write_disable_exec) begin
        write_enable_latch <= 1'b0;
      end
      if (auto_increment_set) begin
        auto_increment_program_flag <= 1'b1;
      end else if (write_disable_exec) begin
        auto_increment_program_flag <= 1'b0;
      end
      if (cs_end) begin
        status_armed <= arm_exec;
      end
    end
  end

  // ----------------------------------------------------------------
  // Protection bits
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      block_protect_lo <= flash_cmd_pkg::STATUS_BIT_RST;
      block_protect_hi <= flash_cmd_pkg::STATUS_BIT_RST;
      protect_lock_bit <= flash_cmd_pkg::STATUS_BIT_RST;
    end else if (ce & status_write_apply) begin
      block_protect_lo <= wr_data[flash_cmd_pkg::BP_LO_POS];
      block_protect_hi <= wr_data[flash_cmd_pkg::BP_HI_POS];
      protect_lock_bit <= wr_data[flash_cmd_pkg::LOCK_POS];
    end
  end

  // ----------------------------------------------------------------
  // Identification output
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      id_sel <= 1'b0;
      id_idx <= flash_cmd_pkg::BIT_MSB;
      miso <= 1'b0;
      miso_oe <= 1'b0;
    end else if (ce) begin
      if (cs_end) begin
        miso_oe <= 1'b0;
      end else if (addr_done & (state == flash_cmd_pkg::ST_ADDR)) begin
        id_sel <= next_shreg[0];
        id_idx <= flash_cmd_pkg::BIT_MSB;
      end else if (fall) begin
        miso <= id_byte[id_idx];
        miso_oe <= 1'b1;
        id_idx <= id_idx - 3'h1;
        if (id_idx == 3'h0) begin
          id_sel <= ~id_sel;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_arm_then_write;
    arm_exec ##1 status_armed;
  endsequence

  chk_disable_clears_latches: assert property (write_disable_exec
    & ~auto_increment_set |=> ~write_enable_latch & ~auto_increment_program_flag)
    else $error("write disable left a latch set");

  chk_write_enable_cmd_sets_latch: assert property (write_enable_exec |=> write_enable_latch)
    else $error("write enable did not set latch");

  chk_arm_single_use: assert property (cs_end & ~arm_exec |=> ~status_armed)
    else $error("status arm survived another instruction");

  chk_arm_opens_status: assert property (arm_exec |-> s_arm_then_write)
    else $error("status arm lost before next instruction");

  chk_locked_ignored: assert property (status_write_exec & ~ev.wp_high & protect_lock_bit
    |=> $stable({protect_lock_bit, block_protect_hi, block_protect_lo}))
    else $error("locked status register changed");

  chk_lock_no_release: assert property (ce & protect_lock_bit & ~ev.wp_high
    |=> protect_lock_bit)
    else $error("lock bit cleared while protect pin low");

  chk_open_write_takes: assert property (status_write_exec & status_open |=>
    protect_lock_bit == $past(wr_data[flash_cmd_pkg::LOCK_POS])
    && block_protect_hi == $past(wr_data[flash_cmd_pkg::BP_HI_POS])
    && block_protect_lo == $past(wr_data[flash_cmd_pkg::BP_LO_POS]))
    else $error("permitted status write not applied");

  chk_unarmed_no_write: assert property (exec & ~status_armed
    |=> $stable({protect_lock_bit, block_protect_hi, block_protect_lo}))
    else $error("status changed without arming");

  chk_id_entry: assert property (addr_done & (state == flash_cmd_pkg::ST_ADDR)
    & ~cs_end |=> state == flash_cmd_pkg::ST_ID && id_sel == $past(next_shreg[0]))
    else $error("id read did not select code from address");

  chk_id_alternate: assert property (fall & ~cs_end & (id_idx == 3'h0)
    |=> id_sel != $past(id_sel))
    else $error("id codes did not alternate");

  chk_release_output: assert property (cs_end |=> ~miso_oe ##1 ~miso_oe)
    else $error("output driven after deselect");

endmodule

// >>> hdl/pin_sync.sv
// Two-stage pin synchronisers and edge detection for the serial bus pins
`timescale 1ns/1ps
module pin_sync (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic wp_n,
  spi_events_if.src ev
);

  logic [3:0] stage1;
  logic [3:0] stage2;
  logic sck_d;
  logic cs_d;

  // ----------------------------------------------------------------
  // Synchronisers: bit 0 sck, 1 cs_n, 2 mosi, 3 wp_n
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      stage1 <= flash_cmd_pkg::PIN_SYNC_RST;
      stage2 <= flash_cmd_pkg::PIN_SYNC_RST;
      sck_d <= 1'b0;
      cs_d <= 1'b1;
    end else if (ce) begin
      stage1 <= {wp_n, mosi, cs_n, sck};
      stage2 <= stage1;
      sck_d <= stage2[0];
      cs_d <= stage2[1];
    end
  end

  // ----------------------------------------------------------------
  // Edge decode from second stage only
  // ----------------------------------------------------------------
  assign ev.sck_rise = stage2[0] & ~sck_d;
  assign ev.sck_fall = ~stage2[0] & sck_d;
  assign ev.cs_fall = ~stage2[1] & cs_d;
  assign ev.cs_rise = stage2[1] & ~cs_d;
  assign ev.selected = ~stage2[1];
  assign ev.din = stage2[2];
  assign ev.wp_high = stage2[3];

endmodule

// >>> hdl/spi_events_if.sv
// Synchronised serial bus events passed from the pin sampler to the interpreter
`timescale 1ns/1ps
interface spi_events_if;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic selected;
  logic din;
  logic wp_high;

  modport src (output sck_rise, sck_fall, cs_fall, cs_rise, selected, din, wp_high);
  modport sink (input sck_rise, sck_fall, cs_fall, cs_rise, selected, din, wp_high);
endinterface

// >>> test/flash_status_protect_id_cmds_tb_top.sv
// Self-checking bench for the flash command interpreter
`timescale 1ns/1ps
module flash_status_protect_id_cmds_tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic wp_n = 1'b1;
  logic auto_increment_set = 1'b0;
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic latch_o;
  logic auto_o;
  logic bp_lo_o;
  logic bp_hi_o;
  logic lock_o;
  logic armed_o;
  logic exp_latch = 1'b0;
  logic exp_auto = 1'b0;
  logic exp_lo = 1'b0;
  logic exp_hi = 1'b0;
  logic lock = 1'b0;
  logic armed = 1'b0;
  logic [15:0] rx;
  logic [7:0] d;
  logic [31:0] r;
  logic [7:0] cd [4] = '{8'h8C, 8'h00, 8'h00, 8'hFF};
  logic [3:0] cw = 4'b0101;
  int errors = 0;
  int n_tests = 0;
  int seed = 32'h3b69;
  wire logic [6:0] seen = {latch_o, auto_o, bp_lo_o, bp_hi_o, lock_o, armed_o, miso_oe};

  always #50 clk = ~clk;

  flash_status_protect_id_cmds dut (.clk(clk), .srst(srst), .ce(ce), .sck(sck), .cs_n(cs_n),
    .mosi(mosi), .wp_n(wp_n), .auto_increment_set(auto_increment_set), .miso(miso),
    .miso_oe(miso_oe), .write_enable_latch(latch_o), .auto_increment_program_flag(auto_o),
    .block_protect_lo(bp_lo_o), .block_protect_hi(bp_hi_o), .protect_lock_bit(lock_o),
    .status_armed(armed_o));

  spi_host_model host (.clk(clk), .sck(sck), .cs_n(cs_n), .mosi(mosi), .miso(miso));

  // ----------------------------------------------------------------
  // Compare and helper tasks
  // ----------------------------------------------------------------
  function automatic logic [6:0] exp_state();
    return {exp_latch, exp_auto, exp_lo, exp_hi, lock, armed, 1'b0};
  endfunction

  task automatic cmp_flags(input logic [6:0] got, input logic [6:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_id(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic run(input logic [7:0] op, input logic [7:0] dat, input int n);
    host.frame({op, dat, 32'h0}, n, 1'b0, rx);
  endtask

  task automatic status_try(input logic [7:0] dat, input logic arm, input logic gap);
    if (arm) begin
      run(flash_cmd_pkg::OP_STATUS_ARM, 8'h00, 8);
      armed = 1'b1;
      cmp_flags(seen, exp_state());
    end
    if (gap) begin
      run(flash_cmd_pkg::OP_WRITE_ENABLE, 8'h00, 8);
      exp_latch = 1'b1;
      armed = 1'b0;
    end
    run(flash_cmd_pkg::OP_STATUS_WRITE, dat, 16);
    if (armed && (wp_n || !lock)) {lock, exp_hi, exp_lo} = {dat[flash_cmd_pkg::LOCK_POS],
      dat[flash_cmd_pkg::BP_HI_POS], dat[flash_cmd_pkg::BP_LO_POS]};
    armed = 1'b0;
    cmp_flags(seen, exp_state());
  endtask

  task automatic close_out();
    $display("counts: %0d compares, %0d mismatches", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    repeat (100) @(posedge clk);
    cmp_flags(seen, exp_state());
    $display("test reset done");
    run(flash_cmd_pkg::OP_WRITE_ENABLE, 8'h00, 8);
    exp_latch = 1'b1;
    cmp_flags(seen, exp_state());
    // Frame sent while the clock enable is low must be missed
    @(posedge clk) ce <= 1'b0;
    run(flash_cmd_pkg::OP_WRITE_DISABLE, 8'h00, 8);
    @(posedge clk) ce <= 1'b1;
    repeat (3) @(posedge clk);
    cmp_flags(seen, exp_state());
    @(posedge clk) auto_increment_set <= 1'b1;
    @(posedge clk) auto_increment_set <= 1'b0;
    repeat (3) @(posedge clk);
    exp_auto = 1'b1;
    cmp_flags(seen, exp_state());
    run(flash_cmd_pkg::OP_WRITE_DISABLE, 8'h00, 7);
    cmp_flags(seen, exp_state());
    host.frame({flash_cmd_pkg::OP_WRITE_DISABLE, 40'h0}, 8, 1'b1, rx);
    repeat (8) @(posedge clk);
    cmp_flags(seen, exp_state());
    host.close_frame();
    {exp_latch, exp_auto} = 2'b00;
    cmp_flags(seen, exp_state());
    $display("test write disable done");
    for (int k = 0; k < 24; k++) begin
      r = $random(seed);
      d = (k < 4) ? cd[k] : r[15:8];
      @(posedge clk) wp_n <= (k < 4) ? cw[k] : r[0];
      status_try(d, (k < 4) | r[1], (k >= 4) & r[2] & r[3]);
    end
    $display("test status write done");
    for (int k = 0; k < 4; k++) begin
      host.frame({k[1] ? flash_cmd_pkg::OP_READ_ID_B : flash_cmd_pkg::OP_READ_ID_A,
                  23'h0, k[0], 16'h0}, 48, 1'b1, rx);
      cmp_flags(seen, exp_state() | 7'h01);
      host.close_frame();
      cmp_id(rx, k[0] ? {flash_cmd_pkg::PART_CODE, flash_cmd_pkg::MAKER_CODE}
                      : {flash_cmd_pkg::MAKER_CODE, flash_cmd_pkg::PART_CODE});
      cmp_flags(seen, exp_state());
    end
    $display("test id read done");
    close_out();
  end

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    close_out();
  end
endmodule

// >>> test/spi_host_model.sv
// Serial bus host model that drives whole frames into the interpreter
`timescale 1ns/1ps
module spi_host_model (
  input wire logic clk,
  output logic sck,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  // Serial clock half period in system clocks
  localparam int HALF = 6;

  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // ----------------------------------------------------------------
  // Frame tasks
  // ----------------------------------------------------------------
  task automatic frame(input logic [47:0] bits, input int n, input bit keep,
                       output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge clk) cs_n <= 1'b0;
    repeat (HALF) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      mosi <= bits[47 - i];
      repeat (HALF) @(posedge clk);
      if (i >= 32) rx = {rx[14:0], miso};
      sck <= 1'b1;
      repeat (HALF) @(posedge clk);
      sck <= 1'b0;
    end
    if (!keep) close_frame();
  endtask

  task automatic close_frame();
    repeat (HALF) @(posedge clk);
    cs_n <= 1'b1;
    // Released data line must not keep its last value
    mosi <= ~mosi;
    repeat (HALF) @(posedge clk);
  endtask
endmodule
